/* hdl/wake_pkg.sv */
// package of constants for the wake input detector
package wake_pkg;
   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] ctrl_addr   = 8'h00;
   localparam logic [7:0] status_addr = 8'h04;
   localparam logic [7:0] flag_addr   = 8'h08;
   localparam logic [7:0] mask_addr   = 8'h0c;
   localparam logic [7:0] mode_addr   = 8'h10;
   // ****************************************
   // field positions
   // ****************************************
   localparam int enable_bit   = 0;
   localparam int level_bit    = 0;
   localparam int sleep_blk_bit = 1;
   localparam int mode_lsb     = 0;
   localparam int flag_rise_bit = 0;
   localparam int flag_fall_bit = 1;
   localparam int flag_width    = 2;
   localparam logic [flag_width-1:0] flag_reset = 2'h0;
   localparam logic [flag_width-1:0] mask_reset = 2'h0;
   // ****************************************
   // chip modes
   // ****************************************
   typedef enum logic [2:0] {
      mode_off, mode_normal, mode_stop, mode_flash,
      mode_sleep, mode_fail_safe, mode_restart
   } chip_mode_t;
   localparam int mode_width = 3;
   // ****************************************
   // timing
   // ****************************************
   localparam int clk_mhz         = 50;
   localparam int filter_min_us   = 10;
   localparam int filter_max_us   = 25;
   localparam int filter_cycles   = filter_min_us * clk_mhz;
   localparam int cnt_width       = 10;
endpackage

/* hdl/wake_filter.sv */
// digital glitch filter with edge outputs for the wake input
`timescale 1ns/1ps
module wake_filter #(
   parameter int filter_len = wake_pkg::filter_cycles,
   parameter int cnt_w      = wake_pkg::cnt_width
) (
   input  wire logic clk_in,
   input  wire logic nrst_in,
   input  wire logic raw_in,
   output logic      level_out,
   output logic      rise_out,
   output logic      fall_out
);
   import wake_pkg::*;

   logic [cnt_w-1:0] count;
   logic             stable;

   // count cycles the raw input differs from the filtered level
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         count <= '0;
      end else if (raw_in == stable) begin
         count <= '0;
      end else begin
         count <= count + 1'b1;
      end
   end

   // accept new level only after it persisted the filter time
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         stable   <= 1'b0;
         rise_out <= 1'b0;
         fall_out <= 1'b0;
      end else if (raw_in != stable &&
                   count == cnt_w'(filter_len - 1)) begin
         stable   <= raw_in;
         rise_out <= raw_in;
         fall_out <= ~raw_in;
      end else begin
         rise_out <= 1'b0;
         fall_out <= 1'b0;
      end
   end

   assign level_out = stable;
endmodule

/* hdl/wake_input_detector.sv */
// wake input detector: filter, wake requests, flags and apb registers
// Function
// - both edge directions count as wake
// - new level must persist the filter time
// - software enable bit for wake capability
// - off mode ignores all wake events
// - live level readable in normal stop flash
// - enabled edge wakes chip from sleep
// - any edge in fail safe forces restart
// - enabled edge in normal stop flash sets flag and interrupt
// - rise and fall interrupts masked separately
// - sleep entry blocked while flags set
// - flags set at sleep entry wake again
`timescale 1ns/1ps
module wake_input_detector #(
   parameter int filter_len = wake_pkg::filter_cycles
) (
   input  wire logic                         clk_in,
   input  wire logic                         nrst_in,
   input  wire logic                         wake_input_in,
   input  wire wake_pkg::chip_mode_t         chip_mode_in,
   input  wire logic                         sleep_request_in,
   input  wire logic                         psel_in,
   input  wire logic                         penable_in,
   input  wire logic                         pwrite_in,
   input  wire logic [7:0]                   paddr_in,
   input  wire logic [31:0]                  pwdata_in,
   output logic      [31:0]                  prdata_out,
   output logic                              pready_out,
   output logic                              pslverr_out,
   output logic                              wake_from_sleep_out,
   output logic                              go_restart_out,
   output logic                              sleep_allowed_out,
   output logic                              irq_out
);
   import wake_pkg::*;

   // ****************************************
   // signals
   // ****************************************
   logic                  level;
   logic                  rise;
   logic                  fall;
   logic                  wake_input_enable;
   logic [flag_width-1:0] wake_flags;
   logic [flag_width-1:0] irq_mask;
   logic [flag_width-1:0] next_flags;
   logic [flag_width-1:0] set_flags;
   logic [flag_width-1:0] clr_flags;
   logic                  powered;
   logic                  report_mode;
   logic                  any_edge;
   logic                  wr_en;
   logic                  rd_en;
   logic                  addr_ok;

   // ****************************************
   // wake input filter
   // ****************************************
   // debounce both directions into edge pulses
   wake_filter #(
      .filter_len (filter_len),
      .cnt_w      (cnt_width)
   ) u_filter (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .raw_in    (wake_input_in),
      .level_out (level),
      .rise_out  (rise),
      .fall_out  (fall)
   );

   // ****************************************
   // mode qualification
   // ****************************************
   // pin is high impedance and ignored while off
   assign powered     = (chip_mode_in != mode_off);
   assign report_mode = (chip_mode_in == mode_normal) ||
                        (chip_mode_in == mode_stop)   ||
                        (chip_mode_in == mode_flash);
   assign any_edge    = powered && (rise || fall);

   // ****************************************
   // apb slave
   // ****************************************
   // zero wait state access with decode
   assign wr_en       = psel_in && penable_in && pwrite_in;
   assign rd_en       = psel_in && !penable_in && !pwrite_in;
   assign pready_out  = 1'b1;
   assign addr_ok     = (paddr_in == ctrl_addr)   ||
                        (paddr_in == status_addr) ||
                        (paddr_in == flag_addr)   ||
                        (paddr_in == mask_addr)   ||
                        (paddr_in == mode_addr);
   assign pslverr_out = psel_in && penable_in && !addr_ok;

   // enable bit written by software
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         wake_input_enable <= 1'b0;
      end else if (wr_en && paddr_in == ctrl_addr) begin
         wake_input_enable <= pwdata_in[enable_bit];
      end
   end

   // per edge interrupt mask, one bit each
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         irq_mask <= mask_reset;
      end else if (wr_en && paddr_in == mask_addr) begin
         irq_mask <= pwdata_in[flag_width-1:0];
      end
   end

   // read data registered in setup phase
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         prdata_out <= 32'h0;
      end else if (rd_en) begin
         prdata_out <= 32'h0;
         if (paddr_in == ctrl_addr) begin
            prdata_out[enable_bit] <= wake_input_enable;
         end else if (paddr_in == status_addr) begin
            prdata_out[level_bit]     <= report_mode && level;
            prdata_out[sleep_blk_bit] <= |wake_flags;
         end else if (paddr_in == flag_addr) begin
            prdata_out[flag_width-1:0] <= wake_flags;
         end else if (paddr_in == mask_addr) begin
            prdata_out[flag_width-1:0] <= irq_mask;
         end else if (paddr_in == mode_addr) begin
            prdata_out[mode_lsb +: mode_width] <= chip_mode_in;
         end
      end
   end

   // ****************************************
   // wake event flags
   // ****************************************
   // edges set flags while enabled in reporting modes
   always_comb begin
      set_flags = '0;
      if (wake_input_enable && report_mode) begin
         set_flags[flag_rise_bit] = rise;
         set_flags[flag_fall_bit] = fall;
      end
   end

   // write one to clear
   assign clr_flags = (wr_en && paddr_in == flag_addr) ?
                      pwdata_in[flag_width-1:0] : '0;

   // set beats clear in the same cycle
   assign next_flags = (wake_flags & ~clr_flags) | set_flags;

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         wake_flags <= flag_reset;
      end else begin
         wake_flags <= next_flags;
      end
   end

   // level interrupt from unmasked flags
   assign irq_out = |(wake_flags & ~irq_mask);

   // ****************************************
   // sleep gating and wake requests
   // ****************************************
   // normal to sleep refused while any flag stands
   assign sleep_allowed_out = sleep_request_in &&
                              (chip_mode_in == mode_normal) &&
                              !(|wake_flags);

   // wake from sleep on enabled edge or leftover flag
   // a flag left set when sleep is reached wakes at once
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         wake_from_sleep_out <= 1'b0;
      end else begin
         wake_from_sleep_out <= (chip_mode_in == mode_sleep) &&
                                ((wake_input_enable && any_edge) ||
                                 (|wake_flags));
      end
   end

   // fail safe always restarts on an edge
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         go_restart_out <= 1'b0;
      end else begin
         go_restart_out <= (chip_mode_in == mode_fail_safe) &&
                           any_edge;
      end
   end

endmodule

/* bench/wake_asserts.sv */
// assertion checker for the wake input detector
`timescale 1ns/1ps
module wake_asserts #(parameter int filter_len = 4) (
   input wire logic                 clk_in,
   input wire logic                 nrst_in,
   input wire logic                 wake_input_in,
   input wire wake_pkg::chip_mode_t chip_mode_in,
   input wire logic                 sleep_request_in,
   input wire logic                 psel_in,
   input wire logic                 penable_in,
   input wire logic                 pwrite_in,
   input wire logic [7:0]           paddr_in,
   input wire logic                 wake_from_sleep_out,
   input wire logic                 go_restart_out,
   input wire logic                 sleep_allowed_out,
   input wire logic                 irq_out
);
   import wake_pkg::*;
   logic [9:0] run;
   logic       prev;
   logic       reg_wr;
   // ****************************************
   // helpers
   // ****************************************
   // samples since the pin last changed
   always_ff @(posedge clk_in) begin
      prev <= wake_input_in;
      if (!nrst_in || wake_input_in != prev)
         run <= 10'h0;
      else if (run != 10'h3ff)
         run <= run + 10'h1;
   end
   // write access to flag or mask register
   assign reg_wr = psel_in && penable_in && pwrite_in &&
                   (paddr_in == flag_addr || paddr_in == mask_addr);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   filter_hold_a: assert property (
      go_restart_out |-> run >= filter_len) else $error("short wake edge");
   restart_mode_a: assert property (
      go_restart_out |-> $past(chip_mode_in) == mode_fail_safe)
      else $error("restart outside fail safe");
   restart_pulse_a: assert property (
      go_restart_out |=> !go_restart_out) else $error("restart too long");
   sleep_wake_a: assert property (
      wake_from_sleep_out |-> $past(chip_mode_in) == mode_sleep)
      else $error("wake outside sleep");
   sleep_gate_a: assert property (
      sleep_allowed_out |-> sleep_request_in && chip_mode_in == mode_normal)
      else $error("sleep allowed without request");
   sleep_flag_a: assert property (
      irq_out |-> !sleep_allowed_out) else $error("sleep with flag set");
   irq_cause_a: assert property (
      $rose(irq_out) |-> $past(reg_wr) ||
      $past(chip_mode_in) inside {mode_normal, mode_stop, mode_flash})
      else $error("interrupt outside reporting modes");
   irq_sticky_a: assert property (
      $fell(irq_out) |-> $past(reg_wr)) else $error("flag lost alone");
endmodule
bind wake_input_detector wake_asserts #(.filter_len(filter_len)) wake_asserts_i
   (.clk_in, .nrst_in, .wake_input_in, .chip_mode_in, .sleep_request_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .wake_from_sleep_out,
    .go_restart_out, .sleep_allowed_out, .irq_out);

/* bench/wake_line_model.sv */
// model of the external wake line driving the pin
`timescale 1ns/1ps
module wake_line_model (
   input  wire logic clk_in,
   input  wire logic level_in,
   input  wire logic glitch_in,
   output logic      wake_out
);
   // pin follows the switch, inverted while a glitch is asked for
   initial wake_out = 1'b0;
   always @(posedge clk_in) begin
      wake_out <= glitch_in ? ~level_in : level_in;
   end
endmodule

/* bench/tb_wake_input_detector.sv */
// self-checking testbench for the wake input detector
`timescale 1ns/1ps
module tb_wake_input_detector;
   import wake_pkg::*;
   localparam int flen = 4;
   logic clk_in = 0, nrst_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0;
   logic sleep_request_in = 0, level_in = 0, glitch_in = 0, err;
   logic wake_input_in, pready_out, pslverr_out, wake_from_sleep_out;
   logic go_restart_out, sleep_allowed_out, irq_out;
   logic [7:0]  paddr_in = 8'h00;
   logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
   chip_mode_t  chip_mode_in = mode_normal;
   int          n_mismatch = 0, n_tests = 0;
   wake_input_detector #(.filter_len(flen)) wake_input_detector_i (
      .clk_in, .nrst_in, .wake_input_in, .chip_mode_in, .sleep_request_in,
      .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
      .pready_out, .pslverr_out, .wake_from_sleep_out, .go_restart_out,
      .sleep_allowed_out, .irq_out);
   wake_line_model wake_line_model_i (.clk_in, .level_in, .glitch_in,
      .wake_out(wake_input_in));
   initial begin
      forever #10 clk_in = ~clk_in;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, waits for pready
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      @(posedge clk_in);
      while (pready_out !== 1'b1) @(posedge clk_in);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   // long enough for model, filter and flag stages
   task automatic settle;
      repeat (flen + 8) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   // set mode and pin, then look for a restart or wake pulse
   task automatic edge_seen(input chip_mode_t md, input logic to,
                            input logic rst, input logic e);
      logic seen;
      @(posedge clk_in);
      chip_mode_in <= md;
      level_in <= to;
      seen = 1'b0;
      repeat (flen + 8) begin
         @(negedge clk_in);
         seen = seen | (rst ? go_restart_out : wake_from_sleep_out);
      end
      chk("wake pulse", e, seen);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (2) @(posedge clk_in);
      nrst_in <= 1'b1;
      rdc(flag_addr, 32'h0, "flags");
      apb(1'b1, ctrl_addr, 32'h1);
      level_in <= 1'b1;
      settle();
      rdc(status_addr, 32'h3, "status");
      sleep_request_in <= 1'b1;
      glitch_in <= 1'b1;
      repeat (2) @(posedge clk_in);
      glitch_in <= 1'b0;
      settle();
      chk("sleep ok", 32'h0, sleep_allowed_out);
      rdc(flag_addr, 32'h1, "rise flag");
      level_in <= 1'b0;
      settle();
      rdc(flag_addr, 32'h3, "both flags");
      for (int m = 1; m < 4; m++) begin
         apb(1'b1, mask_addr, m);
         rdc(mask_addr, m, "mask");
         chk("irq", m != 3, irq_out);
      end
      apb(1'b1, flag_addr, 32'h3);
      rdc(flag_addr, 32'h0, "cleared");
      chk("sleep ok", 32'h1, sleep_allowed_out);
      $display("test normal done");
      level_in <= 1'b1;
      settle();
      rdc(flag_addr, 32'h1, "flag again");
      chip_mode_in <= mode_sleep;
      settle();
      chk("sleep flag", 32'h1, wake_from_sleep_out);
      apb(1'b1, flag_addr, 32'h3);
      edge_seen(mode_sleep, 1'b0, 1'b0, 1'b1);
      apb(1'b1, ctrl_addr, 32'h0);
      edge_seen(mode_sleep, 1'b1, 1'b0, 1'b0);
      apb(1'b1, ctrl_addr, 32'h1);
      edge_seen(mode_fail_safe, 1'b0, 1'b1, 1'b1);
      edge_seen(mode_off, 1'b1, 1'b1, 1'b0);
      @(posedge clk_in);
      chip_mode_in <= mode_normal;
      rdc(flag_addr, 32'h0, "off ignored");
      apb(1'b0, 8'h20, 32'h0);
      chk("unmapped err", 32'h1, err);
      chk("unmapped data", 32'h0, rd);
      $display("test modes done");
      tally_and_finish();
   end
   // watchdog
   initial begin
      repeat (3000) @(posedge clk_in);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
